/* shared/dac_ctrl_pkg.sv */
// Operation
// - Left converter routes by two-bit selector: default, line out, high power.
// - Right converter routes by two-bit selector: default, line out, high power.
// - Coupling 01: left attenuation comes from the right volume register.
// - Coupling 10: right attenuation comes from the left volume register.
// - Coupling 00 and 11: each channel uses its own volume register.
// - Four-bit code selects driver power-on delay, 0 us up to 4 s.
// - Two-bit code selects ramp step time: 0, 1, 2 or 4 ms.
// - One bit selects weak common-mode source: divider or band-gap.
// - Left mute bit mutes left channel except in coupling 01; resets to muted.
// - Seven-bit left attenuation, 0.5 dB per count, 0 to -63.5 dB.
// - Right channel has mute, reset muted, and same attenuation mapping.

package dac_ctrl_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ROUTE_ADDR = 8'h29;
    localparam logic [7:0] POP_ADDR = 8'h2A;
    localparam logic [7:0] LVOL_ADDR = 8'h2B;
    localparam logic [7:0] RVOL_ADDR = 8'h2C;
    localparam logic [7:0] SEQ_STATUS_ADDR = 8'h30;

    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [7:0] POP_RESET = 8'h00;
    localparam logic [7:0] VOL_RESET = 8'h80;
    localparam logic [7:0] ROUTE_WMASK = 8'hF3;
    localparam logic [7:0] POP_WMASK = 8'hFE;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LROUTE_LSB = 6;
    localparam int RROUTE_LSB = 4;
    localparam int DELAY_LSB = 4;
    localparam int STEP_LSB = 2;
    localparam int VCM_BIT = 1;
    localparam int MUTE_BIT = 7;

    localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
    localparam logic [1:0] ROUTE_LINE = 2'h1;
    localparam logic [1:0] ROUTE_HP = 2'h2;
    localparam logic [1:0] COUPLE_L_FROM_R = 2'h1;
    localparam logic [1:0] COUPLE_R_FROM_L = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int US_10 = 10;
    localparam int US_100 = 100;
    localparam int MS_1 = 1;
    localparam int MS_50 = 50;
    localparam int MS_100 = 100;
    localparam int MS_200 = 200;
    localparam int MS_400 = 400;
    localparam int MS_800 = 800;
    localparam int S_2 = 2;
    localparam int S_4 = 4;
    localparam int MS_2 = 2;
    localparam int MS_4 = 4;
    localparam int CYC_10US = US_10 * (CLK_HZ / 1_000_000);
    localparam int CYC_100US = US_100 * (CLK_HZ / 1_000_000);
    localparam int CYC_1MS = MS_1 * (CLK_HZ / 1000);
    localparam int CYC_2MS = MS_2 * (CLK_HZ / 1000);
    localparam int CYC_4MS = MS_4 * (CLK_HZ / 1000);
    localparam int CYC_50MS = MS_50 * (CLK_HZ / 1000);
    localparam int CYC_100MS = MS_100 * (CLK_HZ / 1000);
    localparam int CYC_200MS = MS_200 * (CLK_HZ / 1000);
    localparam int CYC_400MS = MS_400 * (CLK_HZ / 1000);
    localparam int CYC_800MS = MS_800 * (CLK_HZ / 1000);
    localparam int CYC_2S = S_2 * CLK_HZ;
    localparam int CYC_4S = S_4 * CLK_HZ;
    localparam int CNT_W = 28;
endpackage : dac_ctrl_pkg

/* hdl/dac_route_volume_popctl_regs.sv */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dac_route_volume_popctl_regs #(
    // Long counts, shortened in simulation
    parameter int DLY_10US = dac_ctrl_pkg::CYC_10US,
    parameter int DLY_100US = dac_ctrl_pkg::CYC_100US,
    parameter int DLY_1MS = dac_ctrl_pkg::CYC_1MS,
    parameter int DLY_50MS = dac_ctrl_pkg::CYC_50MS,
    parameter int DLY_100MS = dac_ctrl_pkg::CYC_100MS,
    parameter int DLY_200MS = dac_ctrl_pkg::CYC_200MS,
    parameter int DLY_400MS = dac_ctrl_pkg::CYC_400MS,
    parameter int DLY_800MS = dac_ctrl_pkg::CYC_800MS,
    parameter int DLY_2S = dac_ctrl_pkg::CYC_2S,
    parameter int DLY_4S = dac_ctrl_pkg::CYC_4S,
    parameter int STEP_1MS = dac_ctrl_pkg::CYC_1MS,
    parameter int STEP_2MS = dac_ctrl_pkg::CYC_2MS,
    parameter int STEP_4MS = dac_ctrl_pkg::CYC_4MS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic drv_power_req,
    output logic drv_ramp_step,
    output logic drv_ready,
    output logic left_default_path,
    output logic left_line_out_path,
    output logic left_high_power_path,
    output logic right_default_path,
    output logic right_line_out_path,
    output logic right_high_power_path,
    output logic left_mute,
    output logic [6:0] left_atten,
    output logic right_mute,
    output logic [6:0] right_atten,
    output logic vcm_bandgap
);

    typedef enum logic [3:0] {
        SEQ_OFF = 4'h1,
        SEQ_DELAY = 4'h2,
        SEQ_RAMP = 4'h4,
        SEQ_ON = 4'h8
    } seq_type;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] route, pop, lvol, rvol;
    logic [7:0] next_route, next_pop, next_lvol, next_rvol, next_rdata;
    seq_type seq, next_seq;

    always_comb begin
        next_route = route;
        next_pop = pop;
        next_lvol = lvol;
        next_rvol = rvol;
        next_rdata = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                // Reserved bits are held at zero whatever is written
                dac_ctrl_pkg::ROUTE_ADDR:
                    next_route = reg_wdata & dac_ctrl_pkg::ROUTE_WMASK;
                dac_ctrl_pkg::POP_ADDR:
                    next_pop = reg_wdata & dac_ctrl_pkg::POP_WMASK;
                dac_ctrl_pkg::LVOL_ADDR: next_lvol = reg_wdata;
                dac_ctrl_pkg::RVOL_ADDR: next_rvol = reg_wdata;
                default: next_route = route;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                dac_ctrl_pkg::ROUTE_ADDR: next_rdata = route;
                dac_ctrl_pkg::POP_ADDR: next_rdata = pop;
                dac_ctrl_pkg::LVOL_ADDR: next_rdata = lvol;
                dac_ctrl_pkg::RVOL_ADDR: next_rdata = rvol;
                dac_ctrl_pkg::SEQ_STATUS_ADDR: next_rdata = {4'h0, seq};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            route <= dac_ctrl_pkg::ROUTE_RESET;
            pop <= dac_ctrl_pkg::POP_RESET;
            lvol <= dac_ctrl_pkg::VOL_RESET;
            rvol <= dac_ctrl_pkg::VOL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            route <= next_route;
            pop <= next_pop;
            lvol <= next_lvol;
            rvol <= next_rvol;
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Routing and volume outputs
    // ------------------------------------------------------------
    logic [1:0] lsel, rsel, couple;
    logic [7:0] l_src, r_src;

    always_comb begin
        lsel = next_route[dac_ctrl_pkg::LROUTE_LSB +: 2];
        rsel = next_route[dac_ctrl_pkg::RROUTE_LSB +: 2];
        couple = next_route[1:0];
        l_src = next_lvol;
        r_src = next_rvol;
        // Modes 00 and 11 keep both channels independent
        if (couple == dac_ctrl_pkg::COUPLE_L_FROM_R) begin
            l_src = next_rvol;
        end
        if (couple == dac_ctrl_pkg::COUPLE_R_FROM_L) begin
            r_src = next_lvol;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            left_default_path <= 1'b1;
            left_line_out_path <= 1'b0;
            left_high_power_path <= 1'b0;
            right_default_path <= 1'b1;
            right_line_out_path <= 1'b0;
            right_high_power_path <= 1'b0;
            left_mute <= 1'b1;
            left_atten <= 7'h00;
            right_mute <= 1'b1;
            right_atten <= 7'h00;
            vcm_bandgap <= 1'b0;
        end else begin
            // Code 11 is reserved and drives no path at all
            left_default_path <= lsel == dac_ctrl_pkg::ROUTE_DEFAULT;
            left_line_out_path <= lsel == dac_ctrl_pkg::ROUTE_LINE;
            left_high_power_path <= lsel == dac_ctrl_pkg::ROUTE_HP;
            right_default_path <= rsel == dac_ctrl_pkg::ROUTE_DEFAULT;
            right_line_out_path <= rsel == dac_ctrl_pkg::ROUTE_LINE;
            right_high_power_path <= rsel == dac_ctrl_pkg::ROUTE_HP;
            left_mute <= l_src[dac_ctrl_pkg::MUTE_BIT];
            left_atten <= l_src[6:0];
            right_mute <= r_src[dac_ctrl_pkg::MUTE_BIT];
            right_atten <= r_src[6:0];
            vcm_bandgap <= next_pop[dac_ctrl_pkg::VCM_BIT];
        end
    end

    // ------------------------------------------------------------
    // Driver power-up sequencer
    // ------------------------------------------------------------
    logic [dac_ctrl_pkg::CNT_W-1:0] cnt, next_cnt, dly_len, step_len;
    logic next_ready, next_step;

    always_comb begin
        case (pop[dac_ctrl_pkg::DELAY_LSB +: 4])
            4'h1: dly_len = dac_ctrl_pkg::CNT_W'(DLY_10US);
            4'h2: dly_len = dac_ctrl_pkg::CNT_W'(DLY_100US);
            4'h3: dly_len = dac_ctrl_pkg::CNT_W'(DLY_1MS);
            // Codes 0100 and 0101 share one delay, so 1011 is the longest
            4'h4, 4'h5: dly_len = dac_ctrl_pkg::CNT_W'(DLY_50MS);
            4'h6: dly_len = dac_ctrl_pkg::CNT_W'(DLY_100MS);
            4'h7: dly_len = dac_ctrl_pkg::CNT_W'(DLY_200MS);
            4'h8: dly_len = dac_ctrl_pkg::CNT_W'(DLY_400MS);
            4'h9: dly_len = dac_ctrl_pkg::CNT_W'(DLY_800MS);
            4'hA: dly_len = dac_ctrl_pkg::CNT_W'(DLY_2S);
            4'hB: dly_len = dac_ctrl_pkg::CNT_W'(DLY_4S);
            // Reserved codes behave as no delay
            default: dly_len = '0;
        endcase
        case (pop[dac_ctrl_pkg::STEP_LSB +: 2])
            2'h1: step_len = dac_ctrl_pkg::CNT_W'(STEP_1MS);
            2'h2: step_len = dac_ctrl_pkg::CNT_W'(STEP_2MS);
            2'h3: step_len = dac_ctrl_pkg::CNT_W'(STEP_4MS);
            default: step_len = '0;
        endcase
    end

    always_comb begin
        next_seq = seq;
        next_cnt = cnt;
        next_ready = 1'b0;
        next_step = 1'b0;
        case (seq)
            SEQ_OFF: begin
                if (drv_power_req) begin
                    next_seq = SEQ_DELAY;
                    next_cnt = '0;
                end
            end
            SEQ_DELAY: begin
                if (cnt >= dly_len) begin
                    next_seq = SEQ_RAMP;
                    next_cnt = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            SEQ_RAMP: begin
                if (cnt >= step_len) begin
                    next_seq = SEQ_ON;
                    next_step = 1'b1;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            SEQ_ON: begin
                next_ready = 1'b1;
            end
            default: next_seq = SEQ_OFF;
        endcase
        // Dropping the request aborts the sequence at any point
        if (!drv_power_req) begin
            next_seq = SEQ_OFF;
            next_ready = 1'b0;
            next_step = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seq <= SEQ_OFF;
            cnt <= '0;
            drv_ready <= 1'b0;
            drv_ramp_step <= 1'b0;
        end else begin
            seq <= next_seq;
            cnt <= next_cnt;
            drv_ready <= next_ready;
            drv_ramp_step <= next_step;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Outputs and registers load from the same next values, so they agree
    // in every sampled cycle and need no stability guard
    lroute_onehot_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        $past(reg_wr) && $past(reg_addr) == dac_ctrl_pkg::ROUTE_ADDR
        && $past(reg_wdata[7:6]) == 2'h1 |-> left_line_out_path
        && !left_default_path && !left_high_power_path)
        else $error("left route not line out");
    rroute_hp_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[5:4] == 2'h2 |-> right_high_power_path
        && !right_default_path && !right_line_out_path)
        else $error("right route not high power");
    couple_left_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] == 2'h1 |-> left_atten == rvol[6:0]
        && left_mute == rvol[7])
        else $error("left not following right");
    couple_right_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] == 2'h2 |-> right_atten == lvol[6:0]
        && right_mute == lvol[7])
        else $error("right not following left");
    independent_vol_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] == 2'h3 |-> left_atten == lvol[6:0]
        && right_atten == rvol[6:0])
        else $error("independent volume broken");
    left_own_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] != 2'h1 |-> left_mute == lvol[7])
        else $error("left mute not its own");
    right_own_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] != 2'h2 |-> right_mute == rvol[7]
        && right_atten == rvol[6:0])
        else $error("right volume not its own");
    mute_reset_a: assert property (
        @(posedge ref_clk)
        $past(sys_rst) |-> left_mute && right_mute && lvol[7] && rvol[7])
        else $error("channels not muted after reset");
    zero_delay_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        seq == SEQ_OFF && drv_power_req && pop[7:2] == 6'h00
        |-> ##3 drv_ramp_step ##1 drv_ready)
        else $error("zero delay sequence wrong");
    delay_hold_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        seq == SEQ_DELAY && cnt < dly_len && drv_power_req
        |=> seq == SEQ_DELAY)
        else $error("delay ended early");
    delay_top_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        pop[7:4] == 4'hB |-> dly_len == dac_ctrl_pkg::CNT_W'(DLY_4S))
        else $error("top delay code not longest delay");
    delay_pair_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        pop[7:4] == 4'h5 |-> dly_len == dac_ctrl_pkg::CNT_W'(DLY_50MS))
        else $error("delay code five wrong");
    step_pulse_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        drv_ramp_step |=> !drv_ramp_step)
        else $error("ramp step longer than one cycle");
    ready_after_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        drv_ramp_step && drv_power_req |=> drv_ready)
        else $error("driver not ready after ramp step");
    ready_drop_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        !drv_power_req |=> !drv_ready && !drv_ramp_step)
        else $error("driver up without request");
    vcm_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        vcm_bandgap == pop[dac_ctrl_pkg::VCM_BIT])
        else $error("common-mode source wrong");
    atten_a: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        route[1:0] == 2'h0 |-> left_atten == lvol[6:0])
        else $error("left attenuation wrong");

endmodule : dac_route_volume_popctl_regs

`default_nettype wire

/* testbench/dac_route_volume_popctl_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module dac_route_volume_popctl_regs_bench;
    // ------------------------------------------------------------
    // Shortened delay and step counts, in clock cycles
    // ------------------------------------------------------------
    // Codes 4 and 5 give the same power-on delay
    localparam int DLY [0:15] = '{0, 2, 3, 4, 5, 5, 7, 8, 9, 10, 11, 12,
        0, 0, 0, 0};
    localparam int STP [0:3] = '{0, 2, 3, 4};

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic drv_power_req = 1'b0;
    logic [7:0] reg_rdata;
    logic drv_ramp_step, drv_ready, vcm_bandgap, left_mute, right_mute;
    logic [6:0] left_atten, right_atten;
    logic l_def, l_line, l_hp, r_def, r_line, r_hp;
    int n_fail = 0;
    int tests_run = 0;

    always #12.5 ref_clk = ~ref_clk;

    dac_route_volume_popctl_regs #(
        .DLY_10US(DLY[1]), .DLY_100US(DLY[2]), .DLY_1MS(DLY[3]),
        .DLY_50MS(DLY[4]), .DLY_100MS(DLY[6]), .DLY_200MS(DLY[7]),
        .DLY_400MS(DLY[8]), .DLY_800MS(DLY[9]), .DLY_2S(DLY[10]),
        .DLY_4S(DLY[11]), .STEP_1MS(STP[1]), .STEP_2MS(STP[2]),
        .STEP_4MS(STP[3])
    ) dac_route_volume_popctl_regs_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .drv_power_req(drv_power_req),
        .drv_ramp_step(drv_ramp_step), .drv_ready(drv_ready),
        .left_default_path(l_def), .left_line_out_path(l_line),
        .left_high_power_path(l_hp), .right_default_path(r_def),
        .right_line_out_path(r_line), .right_high_power_path(r_hp),
        .left_mute(left_mute), .left_atten(left_atten),
        .right_mute(right_mute), .right_atten(right_atten),
        .vcm_bandgap(vcm_bandgap)
    );

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_cnt(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    // Write taken at the second edge; outputs settle just after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand in the cycle after the strobe only, then zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
        @(posedge ref_clk);
        #1;
        chk8(reg_rdata, 8'h00);
    endtask : rd

    function automatic logic [2:0] one_hot(input int c);
        return (c == 0) ? 3'h4 : (c == 1) ? 3'h2 : 3'h1;
    endfunction : one_hot

    // Power one driver up with delay code d and step code s, then down
    task automatic seq(input int d, input int s);
        int n;
        wr(dac_ctrl_pkg::POP_ADDR, {d[3:0], s[1:0], 2'h0});
        @(posedge ref_clk);
        drv_power_req <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (drv_ramp_step !== 1'b1 && n < 100);
        chk_cnt(n, DLY[d] + STP[s] + 3);
        @(posedge ref_clk);
        #1;
        chk8({6'h00, drv_ramp_step, drv_ready}, 8'h01);
        @(posedge ref_clk);
        drv_power_req <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk8({7'h0, drv_ready}, 8'h00);
    endtask : seq

    task automatic end_of_test;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(dac_ctrl_pkg::ROUTE_ADDR, 8'h00);
        rd(dac_ctrl_pkg::POP_ADDR, 8'h00);
        rd(dac_ctrl_pkg::LVOL_ADDR, 8'h80);
        rd(dac_ctrl_pkg::RVOL_ADDR, 8'h80);
        rd(dac_ctrl_pkg::SEQ_STATUS_ADDR, 8'h01);
        chk8({4'h0, left_mute, right_mute, l_def, r_def}, 8'h0F);
        // Unmapped place: write ignored, read gives zero
        wr(8'h2D, 8'h5A);
        rd(8'h2D, 8'h00);
        // Reserved selector code and reserved bits are never written
        for (int l = 0; l < 3; l++) begin
            for (int r = 0; r < 3; r++) begin
                wr(dac_ctrl_pkg::ROUTE_ADDR, {l[1:0], r[1:0], 4'h0});
                chk8({2'h0, l_def, l_line, l_hp, r_def, r_line, r_hp},
                    {2'h0, one_hot(l), one_hot(r)});
            end
        end
        rd(dac_ctrl_pkg::ROUTE_ADDR, 8'hA0);
        // Coupling: each mode against distinct left and right settings
        wr(dac_ctrl_pkg::LVOL_ADDR, 8'h05);
        wr(dac_ctrl_pkg::RVOL_ADDR, 8'h8A);
        for (int c = 0; c < 4; c++) begin
            wr(dac_ctrl_pkg::ROUTE_ADDR, {6'h00, c[1:0]});
            chk8({left_mute, left_atten},
                (c == 1) ? 8'h8A : 8'h05);
            chk8({right_mute, right_atten},
                (c == 2) ? 8'h05 : 8'h8A);
        end
        rd(dac_ctrl_pkg::ROUTE_ADDR, 8'h03);
        wr(dac_ctrl_pkg::ROUTE_ADDR, 8'h00);
        wr(dac_ctrl_pkg::LVOL_ADDR, 8'h7F);
        chk8({left_mute, left_atten}, 8'h7F);
        rd(dac_ctrl_pkg::LVOL_ADDR, 8'h7F);
        wr(dac_ctrl_pkg::RVOL_ADDR, 8'h00);
        chk8({right_mute, right_atten}, 8'h00);
        // Common-mode source both ways
        wr(dac_ctrl_pkg::POP_ADDR, 8'h02);
        chk8({7'h0, vcm_bandgap}, 8'h01);
        rd(dac_ctrl_pkg::POP_ADDR, 8'h02);
        wr(dac_ctrl_pkg::POP_ADDR, 8'h00);
        chk8({7'h0, vcm_bandgap}, 8'h00);
        // Every documented delay code, then every step code
        for (int d = 0; d < 12; d++) begin
            seq(d, 0);
        end
        for (int s = 1; s < 4; s++) begin
            seq(0, s);
        end
        seq(11, 3);
        rd(dac_ctrl_pkg::POP_ADDR, 8'hBC);
        // Reset in mid-run brings the channels back muted
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(dac_ctrl_pkg::LVOL_ADDR, 8'h80);
        chk8({4'h0, left_mute, right_mute, l_def, r_def}, 8'h0F);
        end_of_test();
    end
endmodule : dac_route_volume_popctl_regs_bench

`default_nettype wire
